// ### hdl/cia_defines.svh
`ifndef CIA_DEFINES_SVH
`define CIA_DEFINES_SVH
`define CIA_ENC_ACK0      14'h3200
`define CIA_ENC_ACK1      14'h3300
`define CIA_ENC_GRP0EN    14'h3306
`define CIA_SPECIAL_1020  24'h0003FC
`define CIA_SPECIAL_1021  24'h0003FD
`define CIA_SPECIAL_1023  24'h0003FF
`define CIA_ID_HI_LSB     16
`define CIA_ID_WIDTH_16   3'h0
`define CIA_ID_WIDTH_24   3'h1
`define CIA_GRP0EN_BIT    0
`define CIA_GRP0EN_RESET  1'h0
`endif

// ### hdl/cia_pkg.sv
package cia_pkg;
	typedef enum logic [1:0] {CIA_EL0, CIA_EL1, CIA_EL2, CIA_EL3} cia_el_t;
	typedef enum logic [2:0] {CIA_RES_OK, CIA_RES_UNDEF, CIA_RES_TRAP_EL2,
		CIA_RES_TRAP_EL3, CIA_RES_VIRTUAL} cia_result_t;
endpackage

// ### hdl/cia_access_check.sv
`timescale 1ns/100ps
`include "cia_defines.svh"
// access screening for one system register access; combinational
module cia_access_check
(
	input  wire logic [13:0]          encoding,
	input  wire logic                 isWrite,
	input  wire cia_pkg::cia_el_t     el,
	input  wire logic                 nonSecure,
	input  wire logic [2:0]           sysregIfaceEnable,
	input  wire logic                 fiqRouteOverride,
	input  wire logic                 irqRouteOverride,
	input  wire logic                 trapAllGroup0,
	input  wire logic                 trapAllGroup1,
	input  wire logic                 trapCoproc12,
	input  wire logic                 monIrqRoute,
	input  wire logic                 monFiqRoute,
	input  wire logic                 el3Is64,
	output cia_pkg::cia_result_t      result,
	output logic                      mapped
);
	logic isAck0;
	logic isAck1;
	logic isEn0;
	logic nsEl1;
	always_comb
	begin
		isAck0 = (encoding == `CIA_ENC_ACK0) && !isWrite;
		isAck1 = (encoding == `CIA_ENC_ACK1) && !isWrite;
		isEn0  = (encoding == `CIA_ENC_GRP0EN);
		mapped = isAck0 || isAck1 || isEn0;
		nsEl1  = nonSecure && (el == cia_pkg::CIA_EL1);
		result = cia_pkg::CIA_RES_OK;
		// priority: undefined first, then traps, then redirection
		if (!mapped || el == cia_pkg::CIA_EL0)
			result = cia_pkg::CIA_RES_UNDEF;
		else if (!sysregIfaceEnable[el - 2'h1])
			result = cia_pkg::CIA_RES_UNDEF;
		else if (nsEl1 && trapCoproc12)
			result = cia_pkg::CIA_RES_TRAP_EL2;
		else if (nsEl1 && (isAck0 || isEn0) && trapAllGroup0)
			result = cia_pkg::CIA_RES_TRAP_EL2;
		else if (nsEl1 && isAck1 && trapAllGroup1)
			result = cia_pkg::CIA_RES_TRAP_EL2;
		else if (!nonSecure && el == cia_pkg::CIA_EL1 && isAck1 && monIrqRoute && el3Is64)
			result = cia_pkg::CIA_RES_TRAP_EL3;
		else if (el == cia_pkg::CIA_EL2 && isEn0 && monFiqRoute && el3Is64)
			result = cia_pkg::CIA_RES_TRAP_EL3;
		else if (nsEl1 && (isAck0 || isEn0) && fiqRouteOverride)
			result = cia_pkg::CIA_RES_VIRTUAL;
		else if (nsEl1 && isAck1 && irqRouteOverride)
			result = cia_pkg::CIA_RES_VIRTUAL;
	end
endmodule

// ### hdl/cia_cpu_iface.sv
`timescale 1ns/100ps
`include "cia_defines.svh"
// Overview of operation
// - group 0 read returns highest pending ID
// - unobservable group 0 gives 1020/1021/1023
// - group 1 read returns and acknowledges ID
// - group 1 special value only 1023
// - ID width 16 or 24, reported
// - fiq override redirects ns EL1 group 0
// - irq override redirects ns EL1 group 1
// - acknowledge reads self-synchronise when masked
// - disabling group 0 releases pending interrupt
// - trap-all-group0 sends ns EL1 to EL2
// - trap-all-group1 sends ns EL1 to EL2
// - coproc12 trap sends ns EL1 to EL2
// - disabled sysreg interface makes access undefined
// - monitor irq route traps secure EL1
// - monitor fiq route traps EL2 enable
// - one register instance for both states
// - 32-bit group 0 enable register
// - enable bit 0, resets to 0
module cia_cpu_iface
(
	input  wire logic                 clock,
	input  wire logic                 arst_n,
	input  wire logic                 reqValid,
	input  wire logic [13:0]          reqEncoding,
	input  wire logic                 reqWrite,
	input  wire logic [31:0]          reqWdata,
	input  wire cia_pkg::cia_el_t     reqEl,
	input  wire logic                 reqNonSecure,
	input  wire logic                 reqIrqMasked,
	input  wire logic [2:0]           sysregIfaceEnable,
	input  wire logic                 fiqRouteOverride,
	input  wire logic                 irqRouteOverride,
	input  wire logic                 trapAllGroup0,
	input  wire logic                 trapAllGroup1,
	input  wire logic                 trapCoproc12,
	input  wire logic                 monIrqRoute,
	input  wire logic                 monFiqRoute,
	input  wire logic                 el3Is64,
	input  wire logic                 idWidth24,
	input  wire logic                 pendValid,
	input  wire logic [23:0]          pendId,
	input  wire logic                 pendGroup1,
	input  wire logic                 pendSignalable,
	input  wire logic                 pendAckable,
	input  wire logic [1:0]           pendSpecialReason,
	output logic                      respValid,
	output logic [31:0]               respRdata,
	output cia_pkg::cia_result_t      respResult,
	output logic                      respSync,
	output logic                      ackValid,
	output logic [23:0]               ackId,
	output logic                      releaseValid,
	output logic [23:0]               releaseId,
	output logic [2:0]                idWidthField,
	output logic                      group0Enable
);
	cia_pkg::cia_result_t checkResult;
	logic                 checkMapped;
	logic                 next_respValid;
	logic [31:0]          next_respRdata;
	cia_pkg::cia_result_t next_respResult;
	logic                 next_respSync;
	logic                 next_ackValid;
	logic [23:0]          next_ackId;
	logic                 next_releaseValid;
	logic [23:0]          next_releaseId;
	logic [2:0]           next_idWidthField;
	logic                 next_group0Enable;
	logic [23:0]          specialId;
	logic                 takeOk;
	logic                 isAck0;
	logic                 isAck1;
	logic                 observable;

	cia_access_check u_check
	(
		.encoding          (reqEncoding),
		.isWrite           (reqWrite),
		.el                (reqEl),
		.nonSecure         (reqNonSecure),
		.sysregIfaceEnable (sysregIfaceEnable),
		.fiqRouteOverride  (fiqRouteOverride),
		.irqRouteOverride  (irqRouteOverride),
		.trapAllGroup0     (trapAllGroup0),
		.trapAllGroup1     (trapAllGroup1),
		.trapCoproc12      (trapCoproc12),
		.monIrqRoute       (monIrqRoute),
		.monFiqRoute       (monFiqRoute),
		.el3Is64           (el3Is64),
		.result            (checkResult),
		.mapped            (checkMapped)
	);

	// clear the upper id bits when only 16 are implemented
	function automatic logic [23:0] trimId(input logic [23:0] id, input logic wide);
		trimId = wide ? id : {8'h00, id[`CIA_ID_HI_LSB-1:0]};
	endfunction

	always_comb
	begin
		takeOk     = reqValid && (checkResult == cia_pkg::CIA_RES_OK);
		isAck0     = reqEncoding == `CIA_ENC_ACK0 && !reqWrite;
		isAck1     = reqEncoding == `CIA_ENC_ACK1 && !reqWrite;
		// distributor reason code picks among the group 0 specials
		unique case (pendSpecialReason)
			2'h0: specialId = `CIA_SPECIAL_1020;
			2'h1: specialId = `CIA_SPECIAL_1021;
			default: specialId = `CIA_SPECIAL_1023;
		endcase
		observable = pendValid && pendSignalable && pendAckable;
		next_respValid    = reqValid;
		next_respResult   = checkResult;
		next_respRdata    = 32'h00000000;
		next_respSync     = 1'b0;
		next_ackValid     = 1'b0;
		next_ackId        = ackId;
		next_releaseValid = 1'b0;
		next_releaseId    = releaseId;
		next_idWidthField = idWidth24 ? `CIA_ID_WIDTH_24 : `CIA_ID_WIDTH_16;
		next_group0Enable = group0Enable;
		if (takeOk && isAck0)
		begin
			if (observable && !pendGroup1 && group0Enable)
			begin
				next_respRdata = {8'h00, trimId(pendId, idWidth24)};
				next_ackValid  = 1'b1;
				next_ackId     = trimId(pendId, idWidth24);
			end
			else
				next_respRdata = {8'h00, specialId};
			next_respSync = reqIrqMasked;
		end
		else if (takeOk && isAck1)
		begin
			if (observable && pendGroup1)
			begin
				next_respRdata = {8'h00, trimId(pendId, idWidth24)};
				next_ackValid  = 1'b1;
				next_ackId     = trimId(pendId, idWidth24);
			end
			else
				next_respRdata = {8'h00, `CIA_SPECIAL_1023};
			next_respSync = reqIrqMasked;
		end
		else if (takeOk && reqEncoding == `CIA_ENC_GRP0EN)
		begin
			// single copy, no banking by security state
			if (reqWrite)
				next_group0Enable = reqWdata[`CIA_GRP0EN_BIT];
			else
				next_respRdata = {31'h00000000, group0Enable};
		end
		// a falling enable hands a held group 0 interrupt back
		if (group0Enable && !next_group0Enable && pendValid && !pendGroup1)
		begin
			next_releaseValid = 1'b1;
			next_releaseId    = trimId(pendId, idWidth24);
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			respValid    <= 1'b0;
			respRdata    <= 32'h00000000;
			respResult   <= cia_pkg::CIA_RES_OK;
			respSync     <= 1'b0;
			ackValid     <= 1'b0;
			ackId        <= 24'h000000;
			releaseValid <= 1'b0;
			releaseId    <= 24'h000000;
			idWidthField <= `CIA_ID_WIDTH_16;
			group0Enable <= `CIA_GRP0EN_RESET;
		end
		else
		begin
			respValid    <= next_respValid;
			respRdata    <= next_respRdata;
			respResult   <= next_respResult;
			respSync     <= next_respSync;
			ackValid     <= next_ackValid;
			ackId        <= next_ackId;
			releaseValid <= next_releaseValid;
			releaseId    <= next_releaseId;
			idWidthField <= next_idWidthField;
			group0Enable <= next_group0Enable;
		end
	end

	a_special_no_ack: assert property (@(posedge clock) disable iff (!arst_n)
		respValid && respRdata[23:0] >= 24'h0003FC && respRdata[23:0] <= 24'h0003FF
		|-> !ackValid)
		else $error("special id read acknowledged an interrupt");
	a_ack_matches_data: assert property (@(posedge clock) disable iff (!arst_n)
		ackValid |-> respValid && respRdata[23:0] == ackId && respResult == cia_pkg::CIA_RES_OK)
		else $error("acknowledge id differs from read data");
	a_narrow_id_zero: assert property (@(posedge clock) disable iff (!arst_n)
		$past(!idWidth24) && respValid && $past(reqEncoding != `CIA_ENC_GRP0EN)
		|-> respRdata[31:16] == 16'h0000)
		else $error("upper id bits set in 16-bit mode");
	a_ack1_special: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && !reqWrite && reqEncoding == `CIA_ENC_ACK1
		&& checkResult == cia_pkg::CIA_RES_OK && !(pendValid && pendGroup1
		&& pendSignalable && pendAckable) |=> respRdata == 32'h000003FF)
		else $error("group 1 special is not 1023");
	a_release_on_disable: assert property (@(posedge clock) disable iff (!arst_n)
		$fell(group0Enable) && $past(pendValid) && !$past(pendGroup1) |-> releaseValid)
		else $error("pending interrupt not released");
	a_enable_write: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && reqWrite && reqEncoding == `CIA_ENC_GRP0EN
		&& checkResult == cia_pkg::CIA_RES_OK |=> group0Enable == $past(reqWdata[0]))
		else $error("enable write not stored");
	a_trap_no_change: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && checkResult != cia_pkg::CIA_RES_OK |=> $stable(group0Enable) && !ackValid)
		else $error("refused access changed state");
	a_undef_no_iface: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && reqEl == cia_pkg::CIA_EL1 && !sysregIfaceEnable[0]
		|=> respValid && respResult == cia_pkg::CIA_RES_UNDEF)
		else $error("disabled interface not undefined");
	a_fiq_redirect: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && reqNonSecure && reqEl == cia_pkg::CIA_EL1 && fiqRouteOverride
		&& sysregIfaceEnable[0] && !trapCoproc12 && !trapAllGroup0
		&& reqEncoding == `CIA_ENC_GRP0EN |=> respResult == cia_pkg::CIA_RES_VIRTUAL)
		else $error("group 0 not redirected");
	a_sync_masked: assert property (@(posedge clock) disable iff (!arst_n)
		respSync |-> respValid && respResult == cia_pkg::CIA_RES_OK)
		else $error("sync flag without acknowledge read");
	a_ack0_returns_id: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && !reqWrite && reqEncoding == `CIA_ENC_ACK0
		&& checkResult == cia_pkg::CIA_RES_OK && group0Enable && !pendGroup1
		&& pendValid && pendSignalable && pendAckable
		|=> ackValid && respRdata[15:0] == $past(pendId[15:0]))
		else $error("group 0 acknowledge lost the pending id");
	a_ack0_special: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && !reqWrite && reqEncoding == `CIA_ENC_ACK0
		&& checkResult == cia_pkg::CIA_RES_OK
		&& !(pendValid && pendSignalable && pendAckable)
		|=> !ackValid && respRdata inside {32'h000003FC, 32'h000003FD, 32'h000003FF})
		else $error("group 0 special id out of range");
	a_reason_code: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && !reqWrite && reqEncoding == `CIA_ENC_ACK0
		&& checkResult == cia_pkg::CIA_RES_OK
		&& !pendAckable && pendSpecialReason == 2'h1
		|=> respRdata == 32'h000003FD)
		else $error("reason code did not select 1021");
	a_ack1_returns_id: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && !reqWrite && reqEncoding == `CIA_ENC_ACK1
		&& checkResult == cia_pkg::CIA_RES_OK && pendGroup1
		&& pendValid && pendSignalable && pendAckable
		|=> ackValid && respRdata[15:0] == $past(pendId[15:0]))
		else $error("group 1 acknowledge lost the pending id");
	a_narrow_ack_id: assert property (@(posedge clock) disable iff (!arst_n)
		ackValid && idWidthField == `CIA_ID_WIDTH_16 |-> ackId[23:16] == 8'h00)
		else $error("upper acknowledge id bits set in 16-bit mode");
	a_width_field: assert property (@(posedge clock) disable iff (!arst_n)
		idWidth24 |=> idWidthField == `CIA_ID_WIDTH_24)
		else $error("id width field does not report 24 bits");
	a_virtual_no_ack: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && checkResult == cia_pkg::CIA_RES_VIRTUAL
		|=> !ackValid && respRdata == 32'h00000000)
		else $error("redirected access touched the physical state");
	a_virtual_ack1: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && reqNonSecure && reqEl == cia_pkg::CIA_EL1 && irqRouteOverride
		&& sysregIfaceEnable[0] && !trapCoproc12 && !trapAllGroup1
		&& !reqWrite && reqEncoding == `CIA_ENC_ACK1
		|=> respResult == cia_pkg::CIA_RES_VIRTUAL)
		else $error("group 1 not redirected");
	a_sync_on_mask: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && reqIrqMasked && !reqWrite && checkResult == cia_pkg::CIA_RES_OK
		&& (reqEncoding == `CIA_ENC_ACK0 || reqEncoding == `CIA_ENC_ACK1)
		|=> respSync)
		else $error("masked acknowledge read not synchronised");
	a_release_id: assert property (@(posedge clock) disable iff (!arst_n)
		releaseValid |-> $fell(group0Enable) && !$past(pendGroup1)
		&& releaseId[15:0] == $past(pendId[15:0]))
		else $error("release without a falling enable");
	a_trap_all_group0_trap: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && reqNonSecure && reqEl == cia_pkg::CIA_EL1 && sysregIfaceEnable[0]
		&& !trapCoproc12 && trapAllGroup0
		&& ((reqEncoding == `CIA_ENC_ACK0 && !reqWrite) || reqEncoding == `CIA_ENC_GRP0EN)
		|=> respResult == cia_pkg::CIA_RES_TRAP_EL2)
		else $error("group 0 access not trapped");
	a_trap_all_group1_trap: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && reqNonSecure && reqEl == cia_pkg::CIA_EL1 && sysregIfaceEnable[0]
		&& !trapCoproc12 && trapAllGroup1 && !reqWrite && reqEncoding == `CIA_ENC_ACK1
		|=> respResult == cia_pkg::CIA_RES_TRAP_EL2)
		else $error("group 1 read not trapped");
	a_coproc12_trap: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && checkMapped && reqNonSecure && reqEl == cia_pkg::CIA_EL1
		&& sysregIfaceEnable[0] && trapCoproc12
		|=> respResult == cia_pkg::CIA_RES_TRAP_EL2)
		else $error("coprocessor trap not taken");
	a_unmapped_undef: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && !checkMapped
		|=> respValid && respResult == cia_pkg::CIA_RES_UNDEF)
		else $error("unmapped encoding not undefined");
	a_mon_irq_trap: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && !reqNonSecure && reqEl == cia_pkg::CIA_EL1 && sysregIfaceEnable[0]
		&& !reqWrite && reqEncoding == `CIA_ENC_ACK1 && monIrqRoute && el3Is64
		|=> respResult == cia_pkg::CIA_RES_TRAP_EL3)
		else $error("secure group 1 read not trapped to monitor");
	a_mon_fiq_trap: assert property (@(posedge clock) disable iff (!arst_n)
		reqValid && reqEl == cia_pkg::CIA_EL2 && sysregIfaceEnable[1]
		&& reqEncoding == `CIA_ENC_GRP0EN && monFiqRoute && el3Is64
		|=> respResult == cia_pkg::CIA_RES_TRAP_EL3)
		else $error("enable access not trapped to monitor");
	a_enable_hold: assert property (@(posedge clock) disable iff (!arst_n)
		!(reqValid && reqWrite && reqEncoding == `CIA_ENC_GRP0EN
		&& checkResult == cia_pkg::CIA_RES_OK) |=> $stable(group0Enable))
		else $error("enable changed without a write");
endmodule

// ### verification/cia_dist_model.sv
`timescale 1ns/100ps
// distributor stand-in: one pending slot, cleared when acknowledged
module cia_dist_model
(
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        loadValid,
	input  wire logic [23:0] loadId,
	input  wire logic        loadGroup1,
	input  wire logic        ackValid,
	input  wire logic [23:0] ackId,
	output logic             pendValid,
	output logic [23:0]      pendId,
	output logic             pendGroup1
);
	logic        held;
	logic        heldGroup1;
	logic [23:0] lastId;
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			held <= 1'b0;
		else if (loadValid)
			held <= 1'b1;
		else if (ackValid && ackId == lastId)
			held <= 1'b0; // acknowledged interrupt leaves the slot
		if (loadValid)
			lastId <= loadId;
		if (loadValid)
			heldGroup1 <= loadGroup1;
	end
	// released ids stay pending here, as if forwarded elsewhere
	// empty slot shows inverted id so a stale value never matches
	assign pendValid = held;
	assign pendId = held ? lastId : ~lastId;
	assign pendGroup1 = heldGroup1;
endmodule

// ### verification/cia_cpu_iface_tb.sv
`timescale 1ns/100ps
`include "cia_defines.svh"
module cia_cpu_iface_tb;
	typedef struct packed {logic [10:0] c; logic [13:0] e; logic [1:0] el; logic ns;
		logic [2:0] r;} cia_case_t;
	logic                 clock = 1'b0;
	logic                 arst_n = 1'b0;
	logic                 reqValid = 1'b0;
	logic [13:0]          reqEncoding = 14'h0000;
	logic                 reqWrite = 1'b0;
	logic [31:0]          reqWdata = 32'h00000000;
	cia_pkg::cia_el_t     reqEl = cia_pkg::CIA_EL1;
	logic                 reqNonSecure = 1'b0;
	logic                 reqIrqMasked = 1'b0;
	logic [10:0]          ctl = 11'h000;
	logic                 idWidth24 = 1'b0;
	logic                 pendSignalable = 1'b0;
	logic                 pendAckable = 1'b0;
	logic [1:0]           pendSpecialReason = 2'h0;
	logic                 loadValid = 1'b0;
	logic [23:0]          loadId = 24'h000000;
	logic                 loadGroup1 = 1'b0;
	logic                 pendValid, pendGroup1, respValid, respSync, ackValid, releaseValid;
	logic [23:0]          pendId, ackId, releaseId;
	logic [31:0]          respRdata;
	cia_pkg::cia_result_t respResult;
	logic [2:0]           idWidthField;
	logic                 group0Enable;
	logic [31:0]          rng = 32'h0000E0CE;
	int                   n_mismatch = 0;
	int                   num_checks = 0;
	int                   mEnable = 0;
	cia_case_t            cases [13];
	always #4 clock = ~clock;
	cia_cpu_iface u_dut
	(
		.clock(clock), .arst_n(arst_n), .reqValid(reqValid), .reqEncoding(reqEncoding),
		.reqWrite(reqWrite), .reqWdata(reqWdata), .reqEl(reqEl), .reqNonSecure(reqNonSecure),
		.reqIrqMasked(reqIrqMasked), .sysregIfaceEnable(ctl[2:0]), .fiqRouteOverride(ctl[3]),
		.irqRouteOverride(ctl[4]), .trapAllGroup0(ctl[5]), .trapAllGroup1(ctl[6]),
		.trapCoproc12(ctl[7]), .monIrqRoute(ctl[8]), .monFiqRoute(ctl[9]), .el3Is64(ctl[10]),
		.idWidth24(idWidth24), .pendValid(pendValid), .pendId(pendId), .pendGroup1(pendGroup1),
		.pendSignalable(pendSignalable), .pendAckable(pendAckable),
		.pendSpecialReason(pendSpecialReason), .respValid(respValid), .respRdata(respRdata),
		.respResult(respResult), .respSync(respSync), .ackValid(ackValid), .ackId(ackId),
		.releaseValid(releaseValid), .releaseId(releaseId), .idWidthField(idWidthField),
		.group0Enable(group0Enable)
	);
	cia_dist_model u_dist
	(
		.clock(clock), .arst_n(arst_n), .loadValid(loadValid), .loadId(loadId),
		.loadGroup1(loadGroup1), .ackValid(ackValid), .ackId(ackId), .pendValid(pendValid),
		.pendId(pendId), .pendGroup1(pendGroup1)
	);
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// model of the result code, undefined first and redirection last
	function automatic int exp_result(input logic [13:0] e, input logic w, input int el,
		input logic ns, input logic [10:0] c);
		int a0;
		int a1;
		int en;
		int nsEl1;
		a0 = (e == `CIA_ENC_ACK0) && !w;
		a1 = (e == `CIA_ENC_ACK1) && !w;
		en = (e == `CIA_ENC_GRP0EN);
		nsEl1 = ns && el == 1;
		if (el == 0 || !(a0 || a1 || en) || !c[el - 1])
			return 1;
		if (nsEl1 && (c[7] || (c[5] && !a1) || (c[6] && a1)))
			return 2;
		if (c[10] && ((!ns && el == 1 && a1 && c[8]) || (el == 2 && en && c[9])))
			return 3;
		if (nsEl1 && ((c[3] && !a1) || (c[4] && a1)))
			return 4;
		return 0;
	endfunction
	// narrow ids read back with the top byte cleared
	function automatic logic [31:0] idv(input logic [23:0] id);
		return {8'h00, idWidth24 ? id[23:16] : 8'h00, id[15:0]};
	endfunction
	task automatic pend(input logic [23:0] id, input logic g1, input logic sg, input logic ak,
		input logic [1:0] rs, input logic w);
		@(posedge clock);
		loadValid <= 1'b1;
		loadId <= id;
		loadGroup1 <= g1;
		pendSignalable <= sg;
		pendAckable <= ak;
		pendSpecialReason <= rs;
		idWidth24 <= w;
		@(posedge clock);
		loadValid <= 1'b0;
	endtask
	task automatic acc(input logic [13:0] e, input logic w, input logic [31:0] d,
		input cia_pkg::cia_el_t el, input logic ns, input logic m, input logic [10:0] c);
		@(posedge clock);
		reqValid <= 1'b1;
		reqEncoding <= e;
		reqWrite <= w;
		reqWdata <= d;
		reqEl <= el;
		reqNonSecure <= ns;
		reqIrqMasked <= m;
		ctl <= c;
		@(posedge clock);
		reqValid <= 1'b0;
		reqWdata <= ~d;
		#1;
		check(respValid, 32'h1);
		if (exp_result(e, w, el, ns, c) == 0 && e == `CIA_ENC_GRP0EN && w)
			mEnable = d[0];
		check(respResult, exp_result(e, w, el, ns, c));
		check(group0Enable, mEnable);
	endtask
	initial
	begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		tally_and_finish();
	end
	initial
	begin
		cases = '{'{11'h087, `CIA_ENC_ACK0, 2'h1, 1'b1, 3'h2},
			'{11'h027, `CIA_ENC_ACK0, 2'h1, 1'b1, 3'h2},
			'{11'h027, `CIA_ENC_GRP0EN, 2'h1, 1'b1, 3'h2},
			'{11'h047, `CIA_ENC_ACK1, 2'h1, 1'b1, 3'h2},
			'{11'h006, `CIA_ENC_ACK0, 2'h1, 1'b0, 3'h1},
			'{11'h005, `CIA_ENC_GRP0EN, 2'h2, 1'b1, 3'h1},
			'{11'h086, `CIA_ENC_ACK0, 2'h1, 1'b1, 3'h1},
			'{11'h507, `CIA_ENC_ACK1, 2'h1, 1'b0, 3'h3},
			'{11'h607, `CIA_ENC_GRP0EN, 2'h2, 1'b1, 3'h3},
			'{11'h00F, `CIA_ENC_ACK0, 2'h1, 1'b1, 3'h4},
			'{11'h017, `CIA_ENC_ACK1, 2'h1, 1'b1, 3'h4},
			'{11'h007, `CIA_ENC_ACK0, 2'h0, 1'b1, 3'h1},
			'{11'h007, 14'h3301, 2'h1, 1'b0, 3'h1}};
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		#1;
		check(group0Enable, `CIA_GRP0EN_RESET);
		check(idWidthField, `CIA_ID_WIDTH_16);
		rng = xs(rng);
		acc(`CIA_ENC_GRP0EN, 1'b1, rng | 32'h1, cia_pkg::CIA_EL1, 1'b0, 1'b0, 11'h007);
		check(group0Enable, 32'h1);
		acc(`CIA_ENC_GRP0EN, 1'b0, 32'h0, cia_pkg::CIA_EL2, 1'b1, 1'b0, 11'h007);
		check(respRdata, 32'h1);
		for (int k = 0; k < 4; k++)
		begin
			rng = xs(rng);
			pend(rng[23:0], 1'b0, 1'b1, 1'b1, 2'h0, k[0]);
			acc(`CIA_ENC_ACK0, 1'b0, 32'h0, cia_pkg::CIA_EL1, 1'b0, k[1], 11'h007);
			check(respRdata, idv(rng[23:0]));
			check(ackValid, 32'h1);
			check(respSync, k[1]);
			check(idWidthField, k[0] ? `CIA_ID_WIDTH_24 : `CIA_ID_WIDTH_16);
			if (k[0])
				check(ackId, rng[23:0]);
		end
		for (int r = 0; r < 4; r++)
		begin
			pend(rng[23:0], 1'b0, r != 0, r == 0, r[1:0], 1'b1);
			acc(`CIA_ENC_ACK0, 1'b0, 32'h0, cia_pkg::CIA_EL1, 1'b0, 1'b0, 11'h007);
			check(respRdata, r == 0 ? 32'h3FC : r == 1 ? 32'h3FD : 32'h3FF);
			check(ackValid, 32'h0);
		end
		for (int g = 0; g < 3; g++)
		begin
			rng = xs(rng);
			pend(rng[23:0], g != 1, 1'b1, g != 2, 2'h0, 1'b1);
			acc(`CIA_ENC_ACK1, 1'b0, 32'h0, cia_pkg::CIA_EL1, 1'b0, 1'b0, 11'h007);
			check(respRdata, g == 0 ? {8'h00, rng[23:0]} : 32'h3FF);
			check(ackValid, g == 0);
		end
		pend(rng[23:0], 1'b0, 1'b1, 1'b1, 2'h0, 1'b1);
		foreach (cases[i])
		begin
			acc(cases[i].e, cases[i].e == `CIA_ENC_GRP0EN, 32'h0,
				cia_pkg::cia_el_t'(cases[i].el), cases[i].ns, 1'b0, cases[i].c);
			check(respResult, cases[i].r);
			check(respRdata | ackValid, 32'h0);
			check(group0Enable, 32'h1);
		end
		acc(`CIA_ENC_GRP0EN, 1'b1, 32'h0, cia_pkg::CIA_EL1, 1'b0, 1'b0, 11'h007);
		check(group0Enable, 32'h0);
		check(releaseValid, 32'h1);
		check(releaseId, rng[23:0]);
		tally_and_finish();
	end
endmodule
